// File: core/pfs_pkg.sv
// Constants and types for the pin function select and slew block.
// How it works
// - Each pin's 2-bit slew code is msb from one register, lsb from another.
// - Slew code 00 fastest, 01 four, 10 eight, 11 sixteen times slower.
// - Slew register bits drive the pad slew controls directly and continuously.
// - A remapped output overrides every other digital function on a non-analog pin.
// - A remapped function never overrides the pin's analog function.
// - Input routing and output routing use separate independent registers.
// - Bidirectional pins take remapped inputs and outputs; input-only pins take inputs.
// - Each remappable input has an 8-bit field naming the pin number.
// - Code 0 grounds the input, 1 picks comparator one, 181 input pin.
// - Timer-2 clock select sits in bits 7-0; upper bits read zero.
// - A lock with a two-key unlock guards established routing.
// - Overvoltage detect tri-states all pins until it clears.
// - Pins shared with analog inputs come up analog after any reset.
// - Analog pins have digital input off and read zero in level and latch.
// - The output driver may be enabled while the analog function is on.
// - Pin functions follow fixed priority; higher enabled ones block lower.
// - Each pin has independent weak pull-up and pull-down enable bits.
package pfs_pkg;
  localparam int NPIN  = 8;
  localparam int NINO  = 8;
  localparam int NPOUT = 4;
  localparam int AW    = 7;
  localparam int OR_W  = 3;
  localparam logic [AW-1:0] OFF_ANALOG = 7'h00;
  localparam logic [AW-1:0] OFF_DIR    = 7'h04;
  localparam logic [AW-1:0] OFF_LATCH  = 7'h08;
  localparam logic [AW-1:0] OFF_LEVEL  = 7'h0C;
  localparam logic [AW-1:0] OFF_PU     = 7'h10;
  localparam logic [AW-1:0] OFF_PD     = 7'h14;
  localparam logic [AW-1:0] OFF_SMSB   = 7'h18;
  localparam logic [AW-1:0] OFF_SLSB   = 7'h1C;
  localparam logic [AW-1:0] OFF_T2SEL  = 7'h20;
  localparam logic [AW-1:0] OFF_SL1SEL = 7'h24;
  localparam logic [AW-1:0] OFF_SL2SEL = 7'h28;
  localparam logic [AW-1:0] OFF_LOCK   = 7'h2C;
  localparam logic [AW-1:0] OFF_OROUTE = 7'h30;
  localparam logic [7:0] ANALOG_RST = 8'hFF;
  localparam logic [7:0] DIR_RST    = 8'hFF;
  localparam logic [7:0] SEL_GND    = 8'h00;
  localparam logic [7:0] SEL_CMP    = 8'h01;
  localparam logic [7:0] SEL_BIDIR  = 8'h20;
  localparam logic [7:0] SEL_BID_E  = 8'h28;
  localparam logic [7:0] SEL_INO    = 8'hB0;
  localparam logic [7:0] SEL_INO_E  = 8'hB8;
  localparam logic [7:0] KEY_A      = 8'h55;
  localparam logic [7:0] KEY_B      = 8'hAA;
  localparam logic [OR_W-1:0] OR_NONE = 3'h0;
  localparam logic [OR_W-1:0] OR_LAST = 3'h4;
  typedef enum logic [1:0] {
    SLEW_FAST = 2'b00,
    SLEW_X4   = 2'b01,
    SLEW_X8   = 2'b10,
    SLEW_X16  = 2'b11
  } pfs_slew_t;
  typedef enum logic [1:0] {
    LK_OPEN = 2'b00,
    LK_SHUT = 2'b01,
    LK_KEY  = 2'b10
  } pfs_lock_t;
  typedef struct packed {
    logic      out;
    logic      oe_n;
    logic      pu;
    logic      pd;
    pfs_slew_t slew;
  } pfs_pad_t;
  typedef struct packed {
    logic en;
    logic oe;
    logic out;
  } pfs_fix_t;
endpackage

// File: core/pfs_pin_config.sv
// Pin configuration block: slew, routing, analog select, pulls and overvoltage.
`timescale 1ns/1ps
module pfs_pin_config (
  input  wire logic                                  clock,
  input  wire logic                                  rst,
  input  wire logic                                  ce,
  input  wire logic [pfs_pkg::AW-1:0]                avs_address,
  input  wire logic                                  avs_read,
  input  wire logic                                  avs_write,
  input  wire logic [31:0]                           avs_writedata,
  input  wire logic [3:0]                            avs_byteenable,
  output logic [31:0]                                avs_readdata,
  output logic                                       avs_waitrequest,
  input  wire logic [pfs_pkg::NPIN-1:0]              pin_in,
  input  wire logic [pfs_pkg::NINO-1:0]              ino_pin_in,
  input  wire logic                                  core_overvoltage_detect,
  input  wire logic                                  comparator_one_output,
  input  wire pfs_pkg::pfs_fix_t [pfs_pkg::NPIN-1:0] fix_fn,
  input  wire logic [pfs_pkg::NPOUT-1:0]             periph_out,
  output pfs_pkg::pfs_pad_t [pfs_pkg::NPIN-1:0]      pad,
  output logic [pfs_pkg::NPIN-1:0]                   pin_level,
  output logic                                       timer2_ext_clock_in,
  output logic                                       sensor_link1_in,
  output logic                                       sensor_link2_in,
  output logic                                       route_locked
);
  import pfs_pkg::*;

  logic [NPIN-1:0] analog_select_r;
  logic [NPIN-1:0] direction_r;
  logic [NPIN-1:0] output_latch_r;
  logic [NPIN-1:0] pullup_enable_r;
  logic [NPIN-1:0] pulldown_enable_r;
  logic [NPIN-1:0] slew_msb_r;
  logic [NPIN-1:0] slew_lsb_r;
  logic [7:0]      t2_route_r;
  logic [7:0]      sl1_route_r;
  logic [7:0]      sl2_route_r;
  logic [OR_W-1:0] oroute_r [NPIN];
  pfs_lock_t       lock_r;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NINO-1:0] ino_s1_r;
  logic [NINO-1:0] ino_s2_r;
  logic            hv_s1_r;
  logic            hv_s2_r;
  logic [NPIN-1:0] pin_level_r;
  logic            rd_valid_r;
  logic [31:0]     rdata_nxt;
  logic [31:0]     rdata_r;
  logic            wr_go;
  logic            rt_ok;
  logic [NPIN-1:0] dig_in;

  // Writes complete in the cycle they are presented; reads take one wait.
  assign avs_waitrequest = ~ce | (avs_read & ~rd_valid_r);
  assign wr_go           = ce & avs_write;
  assign rt_ok           = (lock_r == LK_OPEN);
  assign avs_readdata    = rdata_r;
  assign route_locked    = ~rt_ok;
  assign pin_level       = pin_level_r;
  // Analog pins have their digital input buffer switched off.
  assign dig_in          = pin_s2_r & ~analog_select_r;

  // Outside levels are resynchronised before any logic looks at them.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ino_s1_r <= '0;
      ino_s2_r <= '0;
      hv_s1_r  <= 1'b0;
      hv_s2_r  <= 1'b0;
    end
    else if (ce)
    begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      ino_s1_r <= ino_pin_in;
      ino_s2_r <= ino_s1_r;
      hv_s1_r  <= core_overvoltage_detect;
      hv_s2_r  <= hv_s1_r;
    end
  end

  // Port configuration registers; all take effect the cycle after a write.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      analog_select_r   <= ANALOG_RST;
      direction_r       <= DIR_RST;
      output_latch_r    <= '0;
      pullup_enable_r   <= '0;
      pulldown_enable_r <= '0;
      slew_msb_r        <= '0;
      slew_lsb_r        <= '0;
    end
    else if (wr_go && avs_byteenable[0])
    begin
      case (avs_address)
        OFF_ANALOG: analog_select_r   <= avs_writedata[NPIN-1:0];
        OFF_DIR:    direction_r       <= avs_writedata[NPIN-1:0];
        OFF_LATCH:  output_latch_r    <= avs_writedata[NPIN-1:0];
        OFF_PU:     pullup_enable_r   <= avs_writedata[NPIN-1:0];
        OFF_PD:     pulldown_enable_r <= avs_writedata[NPIN-1:0];
        OFF_SMSB:   slew_msb_r        <= avs_writedata[NPIN-1:0];
        OFF_SLSB:   slew_lsb_r        <= avs_writedata[NPIN-1:0];
        default:    analog_select_r   <= analog_select_r;
      endcase
    end
  end

  // Input routing, one field per peripheral input, separate from outputs.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      t2_route_r  <= SEL_GND;
      sl1_route_r <= SEL_GND;
      sl2_route_r <= SEL_GND;
    end
    else if (wr_go && rt_ok)
    begin
      if (avs_address == OFF_T2SEL && avs_byteenable[0])
        t2_route_r <= avs_writedata[7:0];
      if (avs_address == OFF_SL1SEL && avs_byteenable[1])
        sl1_route_r <= avs_writedata[15:8];
      if (avs_address == OFF_SL2SEL && avs_byteenable[0])
        sl2_route_r <= avs_writedata[7:0];
    end
  end

  // Locking needs two keys in a row to reopen, so a stray write cannot.
  always_ff @(posedge clock)
  begin
    if (rst)
      lock_r <= LK_OPEN;
    else if (wr_go && avs_address == OFF_LOCK && avs_byteenable[0])
    begin
      case (lock_r)
        LK_OPEN: lock_r <= avs_writedata[0] ? LK_SHUT : LK_OPEN;
        LK_SHUT: lock_r <= (avs_writedata[7:0] == KEY_A) ? LK_KEY : LK_SHUT;
        LK_KEY:  lock_r <= (avs_writedata[7:0] == KEY_B) ? LK_OPEN : LK_SHUT;
        default: lock_r <= LK_SHUT;
      endcase
    end
  end

  // Pin number decode: ground, comparator, bidirectional or input-only pins.
  function automatic logic pick(input logic [7:0] s);
    logic [7:0] d;
    logic [7:0] e;
    d = s - SEL_BIDIR;
    e = s - SEL_INO;
    if (s == SEL_CMP)
      pick = comparator_one_output;
    else if (s >= SEL_BIDIR && s < SEL_BID_E)
      pick = dig_in[d[2:0]];
    else if (s >= SEL_INO && s < SEL_INO_E)
      pick = ino_s2_r[e[2:0]];
    else
      pick = 1'b0;
  endfunction

  // Unrouted inputs sit at ground, so a peripheral sees nothing until routed.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      timer2_ext_clock_in <= 1'b0;
      sensor_link1_in     <= 1'b0;
      sensor_link2_in     <= 1'b0;
      pin_level_r         <= '0;
    end
    else if (ce)
    begin
      timer2_ext_clock_in <= pick(t2_route_r);
      sensor_link1_in     <= pick(sl1_route_r);
      sensor_link2_in     <= pick(sl2_route_r);
      pin_level_r         <= dig_in;
    end
  end

  // Per pin: output route field, priority and pad drive.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      logic    rmp;
      logic    rval;
      logic    ana;
      logic    hvb;
      logic    out_r;
      logic    oe_n_r;
      logic    pu_r;
      logic    pd_r;
      always_ff @(posedge clock)
      begin
        if (rst)
          oroute_r[gi] <= OR_NONE;
        else if (wr_go && rt_ok && avs_byteenable[0]
                 && avs_address == OFF_OROUTE + 7'(4 * gi))
          oroute_r[gi] <= avs_writedata[OR_W-1:0];
      end
      assign rmp  = (oroute_r[gi] != OR_NONE) && (oroute_r[gi] <= OR_LAST);
      assign rval = rmp ? periph_out[2'(oroute_r[gi] - 3'h1)] : 1'b0;
      assign ana  = analog_select_r[gi];
      assign hvb  = hv_s2_r;
      // Pulls are their own concern; overvoltage drops them with the drivers.
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          pu_r <= 1'b0;
          pd_r <= 1'b0;
        end
        else if (ce)
        begin
          pu_r <= pullup_enable_r[gi] & ~hvb;
          pd_r <= pulldown_enable_r[gi] & ~hvb;
        end
      end
      // Overvoltage first, then remapped output and fixed function on non-analog pins, then plain port.
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          out_r  <= 1'b0;
          oe_n_r <= 1'b1;
        end
        else if (ce)
        begin
          if (hvb)
          begin
            out_r  <= 1'b0;
            oe_n_r <= 1'b1;
          end
          else if (rmp && !ana)
          begin
            out_r  <= rval;
            oe_n_r <= 1'b0;
          end
          else if (fix_fn[gi].en && !ana)
          begin
            out_r  <= fix_fn[gi].out;
            oe_n_r <= ~fix_fn[gi].oe;
          end
          else
          begin
            // The port driver stays usable under analog; contention is the user's risk.
            out_r  <= output_latch_r[gi];
            oe_n_r <= direction_r[gi];
          end
        end
      end
      assign pad[gi].out  = out_r;
      assign pad[gi].oe_n = oe_n_r;
      assign pad[gi].pu   = pu_r;
      assign pad[gi].pd   = pd_r;
      assign pad[gi].slew = pfs_slew_t'({slew_msb_r[gi], slew_lsb_r[gi]});
    end
  endgenerate

  // Read mux; unmapped and unimplemented bits read zero.
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address)
      OFF_ANALOG: rdata_nxt[NPIN-1:0] = analog_select_r;
      OFF_DIR:    rdata_nxt[NPIN-1:0] = direction_r;
      OFF_LATCH:  rdata_nxt[NPIN-1:0] = output_latch_r & ~analog_select_r;
      OFF_LEVEL:  rdata_nxt[NPIN-1:0] = pin_level_r;
      OFF_PU:     rdata_nxt[NPIN-1:0] = pullup_enable_r;
      OFF_PD:     rdata_nxt[NPIN-1:0] = pulldown_enable_r;
      OFF_SMSB:   rdata_nxt[NPIN-1:0] = slew_msb_r;
      OFF_SLSB:   rdata_nxt[NPIN-1:0] = slew_lsb_r;
      OFF_T2SEL:  rdata_nxt[7:0]      = t2_route_r;
      OFF_SL1SEL: rdata_nxt[15:8]     = sl1_route_r;
      OFF_SL2SEL: rdata_nxt[7:0]      = sl2_route_r;
      OFF_LOCK:   rdata_nxt[0]        = ~rt_ok;
      default:
      begin
        for (int k = 0; k < NPIN; k++)
          if (avs_address == OFF_OROUTE + 7'(4 * k))
            rdata_nxt[OR_W-1:0] = oroute_r[k];
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_valid_r <= 1'b0;
      rdata_r    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      rd_valid_r <= avs_read & ~rd_valid_r;
      rdata_r    <= rdata_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_hv_tristate: assert property (ce && hv_s2_r |=> pad[0].oe_n && pad[NPIN-1].oe_n)
    else $error("Pins not tri-stated under overvoltage.");
  a_analog_in_off: assert property (ce && analog_select_r[0] |=> !pin_level_r[0])
    else $error("Analog pin reads a digital level.");
  a_reset_analog: assert property (rst ##1 !rst |-> analog_select_r == ANALOG_RST)
    else $error("Analog select not set after reset.");
  a_slew_direct: assert property (pad[1].slew == {slew_msb_r[1], slew_lsb_r[1]})
    else $error("Slew code does not follow registers.");
  a_route_ground: assert property (ce && t2_route_r == SEL_GND |=> !timer2_ext_clock_in)
    else $error("Grounded route not low.");
  a_route_181: assert property (ce && t2_route_r == 8'hB5 |=>
      timer2_ext_clock_in == $past(ino_s2_r[5]))
    else $error("Input pin 181 not routed.");
  a_lock_holds: assert property (wr_go && !rt_ok && avs_address == OFF_T2SEL
      |=> $stable(t2_route_r))
    else $error("Locked routing changed.");
  a_remap_wins: assert property (ce && !hv_s2_r && g_pin[0].rmp && !analog_select_r[0]
      |=> !pad[0].oe_n && pad[0].out == $past(g_pin[0].rval))
    else $error("Remapped output did not take the pin.");
  a_analog_first: assert property (ce && !hv_s2_r && analog_select_r[0] && direction_r[0]
      |=> pad[0].oe_n)
    else $error("Remap overrode analog pin.");
  a_read_wait: assert property (ce && avs_read && !rd_valid_r
      |-> avs_waitrequest ##1 (!ce || !avs_waitrequest))
    else $error("Read answer late.");
  // Priority, pulls and bus timing are checked on sample pins only.
  a_pull_follow: assert property (ce && !hv_s2_r |=>
      pad[2].pu == $past(pullup_enable_r[2]) && pad[2].pd == $past(pulldown_enable_r[2]))
    else $error("Pull enables not passed to pin.");
  a_hv_pulls_off: assert property (ce && hv_s2_r |=> !pad[0].pu && !pad[0].pd)
    else $error("Pulls left on under overvoltage.");
  a_route_cmp: assert property (ce && t2_route_r == SEL_CMP |=>
      timer2_ext_clock_in == $past(comparator_one_output))
    else $error("Comparator route not followed.");
  a_route_bidir: assert property (ce && sl1_route_r == SEL_BID_E - 8'h01 |=>
      sensor_link1_in == $past(dig_in[7]))
    else $error("Bidirectional pin route not followed.");
  a_fixed_next: assert property (ce && !hv_s2_r && !g_pin[0].rmp && fix_fn[0].en
      && !analog_select_r[0] |=> pad[0].oe_n == !$past(fix_fn[0].oe))
    else $error("Fixed function lost its pin.");
  a_port_analog: assert property (ce && !hv_s2_r && analog_select_r[0] |=>
      pad[0].oe_n == $past(direction_r[0]) && pad[0].out == $past(output_latch_r[0]))
    else $error("Port driver blocked under analog.");
  a_upper_zero: assert property (ce && avs_read && avs_address == OFF_T2SEL |=>
      avs_readdata[31:8] == 24'h000000)
    else $error("Unimplemented select bits read as one.");
  a_route_write: assert property (wr_go && rt_ok && avs_address == OFF_T2SEL
      && avs_byteenable[0] |=> t2_route_r == $past(avs_writedata[7:0]))
    else $error("Open route write did not land.");
  a_cfg_write: assert property (wr_go && avs_byteenable[0] && avs_address == OFF_SMSB
      |=> slew_msb_r == $past(avs_writedata[NPIN-1:0]))
    else $error("Slew register write did not land.");
  a_write_nowait: assert property (ce && avs_write && !avs_read |-> !avs_waitrequest)
    else $error("Write held off while enabled.");
  a_ce_freeze: assert property (!ce |=>
      $stable(analog_select_r) && $stable(t2_route_r))
    else $error("State moved while clock enable low.");
  a_level_digital: assert property (ce && !analog_select_r[7] |=>
      pin_level_r[7] == $past(pin_s2_r[7]))
    else $error("Digital pin level not passed on.");

  c_read: cover property (avs_read && !avs_waitrequest);
  c_unlock: cover property (lock_r == LK_KEY ##[1:20] lock_r == LK_OPEN);
  c_remap: cover property (g_pin[0].rmp && !pad[0].oe_n);
  c_hv: cover property (hv_s2_r ##1 !hv_s2_r);
  c_fixed: cover property (fix_fn[0].en && !pad[0].oe_n);
endmodule

// File: dv/tb_pin_function_select_and_slew.sv
// Self-checking testbench for the pin configuration block.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_pin_function_select_and_slew;
  import pfs_pkg::*;
  logic                  clock;
  logic                  rst;
  logic                  ce;
  logic [AW-1:0]         avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [31:0]           avs_writedata;
  logic [3:0]            avs_byteenable;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [NPIN-1:0]       pin_in;
  logic [NINO-1:0]       ino_pin_in;
  logic                  core_overvoltage_detect;
  logic                  comparator_one_output;
  pfs_fix_t [NPIN-1:0]   fix_fn;
  logic [NPOUT-1:0]      periph_out;
  pfs_pad_t [NPIN-1:0]   pad;
  logic [NPIN-1:0]       pin_level;
  logic                  timer2_ext_clock_in;
  logic                  sensor_link1_in;
  logic                  sensor_link2_in;
  logic                  route_locked;
  logic [31:0]           rd;
  logic [7:0]            sel_tab [5];
  logic                  exp_tab [5];
  int                    n_fail;
  int                    compares;
  int                    cyc;

  pfs_pin_config i_dut (
    .clock                   (clock),
    .rst                     (rst),
    .ce                      (ce),
    .avs_address             (avs_address),
    .avs_read                (avs_read),
    .avs_write               (avs_write),
    .avs_writedata           (avs_writedata),
    .avs_byteenable          (avs_byteenable),
    .avs_readdata            (avs_readdata),
    .avs_waitrequest         (avs_waitrequest),
    .pin_in                  (pin_in),
    .ino_pin_in              (ino_pin_in),
    .core_overvoltage_detect (core_overvoltage_detect),
    .comparator_one_output   (comparator_one_output),
    .fix_fn                  (fix_fn),
    .periph_out              (periph_out),
    .pad                     (pad),
    .pin_level               (pin_level),
    .timer2_ext_clock_in     (timer2_ext_clock_in),
    .sensor_link1_in         (sensor_link1_in),
    .sensor_link2_in         (sensor_link2_in),
    .route_locked            (route_locked)
  );

  always #10 clock = ~clock;

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int g;
    @(posedge clock);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    g = 0;
    do
    begin
      @(posedge clock);
      g++;
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    `CHK("bus waits", wr ? 1 : 2, g)
  endtask

  task automatic chk_rd(input logic [AW-1:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    `CHK("readback", e, rd)
  endtask

  task automatic chk_pad0(input logic o, input logic oen);
    tick(3);
    `CHK("pad0 out", o, pad[0].out)
    `CHK("pad0 oe_n", oen, pad[0].oe_n)
  endtask

  initial
  begin
    clock = 0; rst = 1; ce = 1; avs_address = '0; avs_read = 0; avs_write = 0;
    avs_writedata = '0; avs_byteenable = '0; pin_in = '0; ino_pin_in = '0;
    core_overvoltage_detect = 0; comparator_one_output = 0; fix_fn = '0;
    periph_out = '0; n_fail = 0; compares = 0; cyc = 0;
    sel_tab = '{8'hB5, 8'h01, 8'h00, 8'h27, 8'h22};
    exp_tab = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    chk_rd(OFF_ANALOG, 32'h000000FF);
    chk_rd(OFF_T2SEL, 32'h0);
    chk_rd(OFF_PU, 32'h0);
    for (int k = 0; k < NPIN; k++)
      `CHK("oe_n reset", 1'b1, pad[k].oe_n)
    // Pins 0, 2, 4 and 6 take the four slew codes in turn.
    bus(1'b1, OFF_SMSB, 32'hF0, 4'h1);
    bus(1'b1, OFF_SLSB, 32'hCC, 4'h1);
    tick(1);
    for (int k = 0; k < NPIN; k++)
      `CHK("slew", {k >= 4, k[1]}, pad[k].slew)
    `CHK("slew x4", SLEW_X4, pad[2].slew)
    `CHK("slew x16", SLEW_X16, pad[6].slew)
    bus(1'b1, OFF_PU, 32'h0F, 4'h1);
    bus(1'b1, OFF_PD, 32'h3C, 4'h1);
    tick(3);
    for (int k = 0; k < NPIN; k++)
    begin
      `CHK("pull up", k < 4, pad[k].pu)
      `CHK("pull down", k >= 2 && k < 6, pad[k].pd)
    end
    @(posedge clock);
    pin_in <= 8'hA5;
    ino_pin_in <= 8'h20;
    comparator_one_output <= 1'b1;
    tick(5);
    `CHK("level analog", 8'h00, pin_level)
    chk_rd(OFF_LEVEL, 32'h0);
    bus(1'b1, OFF_ANALOG, 32'h0F, 4'h1);
    tick(5);
    `CHK("level digital", 8'hA0, pin_level)
    chk_rd(OFF_LEVEL, 32'hA0);
    // Input pin 181, comparator, ground, digital pin 7, then analog pin 2.
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, OFF_T2SEL, {24'hFFFFFF, sel_tab[i]}, 4'hF);
      tick(4);
      `CHK("timer2 route", exp_tab[i], timer2_ext_clock_in)
    end
    chk_rd(OFF_T2SEL, 32'h22);
    bus(1'b1, OFF_SL1SEL, 32'h2700, 4'h2);
    bus(1'b1, OFF_SL2SEL, 32'h01, 4'h1);
    tick(4);
    `CHK("link1 route", 1'b1, sensor_link1_in)
    `CHK("link2 route", 1'b1, sensor_link2_in)
    chk_rd(OFF_SL1SEL, 32'h2700);
    // Pin 0 is still analog: only the port driver may reach the pad.
    @(posedge clock);
    fix_fn[0] <= '{en: 1'b1, oe: 1'b1, out: 1'b0};
    bus(1'b1, OFF_OROUTE, 32'h1, 4'h1);
    bus(1'b1, OFF_DIR, 32'hFE, 4'h1);
    bus(1'b1, OFF_LATCH, 32'h01, 4'h1);
    chk_pad0(1'b1, 1'b0);
    bus(1'b1, OFF_ANALOG, 32'h0, 4'h1);
    chk_pad0(1'b0, 1'b0);
    @(posedge clock);
    periph_out <= 4'h1;
    chk_pad0(1'b1, 1'b0);
    bus(1'b1, OFF_OROUTE, 32'h0, 4'h1);
    chk_pad0(1'b0, 1'b0);
    @(posedge clock);
    fix_fn[0] <= '0;
    chk_pad0(1'b1, 1'b0);
    bus(1'b1, OFF_LOCK, 32'h1, 4'h1);
    tick(1);
    `CHK("locked", 1'b1, route_locked)
    bus(1'b1, OFF_T2SEL, 32'h01, 4'h1);
    chk_rd(OFF_T2SEL, 32'h22);
    bus(1'b1, OFF_LOCK, 32'h55, 4'h1);
    bus(1'b1, OFF_LOCK, 32'hAA, 4'h1);
    tick(1);
    `CHK("unlocked", 1'b0, route_locked)
    bus(1'b1, OFF_T2SEL, 32'h01, 4'h1);
    chk_rd(OFF_T2SEL, 32'h01);
    chk_rd(7'h7C, 32'h0);
    @(posedge clock);
    ce <= 1'b0;
    #1;
    `CHK("stalled", 1'b1, avs_waitrequest)
    @(posedge clock);
    ce <= 1'b1;
    core_overvoltage_detect <= 1'b1;
    tick(5);
    for (int k = 0; k < NPIN; k++)
    begin
      `CHK("overvolt oe_n", 1'b1, pad[k].oe_n)
      `CHK("overvolt pu", 1'b0, pad[k].pu)
    end
    @(posedge clock);
    core_overvoltage_detect <= 1'b0;
    chk_pad0(1'b1, 1'b0);
    // A second reset in mid-run must restore every default.
    @(posedge clock);
    rst <= 1'b1;
    tick(2);
    @(posedge clock);
    rst <= 1'b0;
    chk_rd(OFF_T2SEL, 32'h0);
    chk_rd(OFF_ANALOG, 32'h000000FF);
    `CHK("pad0 released", 1'b1, pad[0].oe_n)
    stop_test();
  end
endmodule
